// *** shared/mmit_regs.svh ***
// register offsets, codes and timing constants of the interval timer
`ifndef MMIT_REGS_SVH
`define MMIT_REGS_SVH
`define MMIT_CLK_MHZ        250
`define MMIT_TICK_US        100
`define MMIT_TICK_CYC       (`MMIT_CLK_MHZ * `MMIT_TICK_US)
`define MMIT_MIN_PERIOD_US  500
`define MMIT_MIN_PERIOD     (`MMIT_MIN_PERIOD_US / `MMIT_TICK_US)
`define MMIT_MAX_SINGLE     32'h0000_FFFF
`define MMIT_MAX_CASCADE    32'hFFFF_FFFF
`define MMIT_MODE_IDLE      16'h0000
`define MMIT_MODE_ONE_SHOT  16'h1000
`define MMIT_MODE_PERIODIC  16'h1001
`define MMIT_MODE_FREE_RUN  16'h1002
`define MMIT_MODE_HALTED    16'h1003
`define MMIT_MODE_CLEARED   16'h1004
`define MMIT_STATUS_REQUEST 8'h1C
// per-channel window of 0x20 bytes, six channels (4 single, 2 cascaded)
`define MMIT_CH_STRIDE_LOG2 5
`define MMIT_OFS_CMD        3'h0
`define MMIT_OFS_EVENT      3'h1
`define MMIT_OFS_PERIOD     3'h2
`define MMIT_OFS_VALUE      3'h3
`define MMIT_OFS_MODE       3'h4
`define MMIT_OFS_PEND_EVT   3'h5
`define MMIT_OFS_PEND_PER   3'h6
`define MMIT_OFS_ERROR      3'h7
`define MMIT_NUM_CH         6
// channels below this index are single, the rest cascaded pairs
`define MMIT_NUM_SINGLE     4
`endif

// *** shared/mmit_pkg.sv ***
// types shared by the interval timer modules
package mmit_pkg;
  // one command toward a channel
  typedef struct packed {
    logic        valid;
    logic [15:0] code;
    logic [31:0] event_code;
    logic [31:0] period;
  } mmit_cmd_t;
  // the four status words of one channel
  typedef struct packed {
    logic [31:0] value;
    logic [31:0] mode;
    logic [31:0] event_code;
    logic [31:0] period;
  } mmit_status_t;
  // event pulse toward the processor
  typedef struct packed {
    logic        fire;
    logic [2:0]  channel;
    logic [31:0] event_code;
  } mmit_event_t;
  typedef enum logic [2:0] {
    MMIT_ST_IDLE     = 3'b000,
    MMIT_ST_ONE_SHOT = 3'b001,
    MMIT_ST_PERIODIC = 3'b011,
    MMIT_ST_FREE_RUN = 3'b010,
    MMIT_ST_HALTED   = 3'b110,
    MMIT_ST_CLEARED  = 3'b111
  } mmit_state_t;
endpackage

// *** core/mmit_prescaler.sv ***
// 100 us tick generator from the core clock
`timescale 1ns/1ps
`include "mmit_regs.svh"
module mmit_prescaler (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      tick
);
  localparam int unsigned TICK_CYC = `MMIT_TICK_CYC;
  logic [15:0] count;
  wire         wrap = (count == 16'(TICK_CYC - 1));
  // free counter; one shared tick keeps all channels in step
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      count <= wrap ? 16'h0000 : 16'(count + 16'h0001);
      tick  <= wrap;
    end
  end
endmodule

// *** core/mmit_channel.sv ***
// one interval timer channel: mode machine, count, event pulse
`timescale 1ns/1ps
`include "mmit_regs.svh"
module mmit_channel (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                tick,
  input  wire logic [31:0]         max_period,
  input  wire mmit_pkg::mmit_cmd_t cmd,
  output mmit_pkg::mmit_status_t   status,
  output logic                     fire,
  output logic                     param_err
);
  import mmit_pkg::*;
  mmit_state_t state;
  logic [31:0] count;
  logic [31:0] event_code;
  logic [31:0] period;
  // parameter checks on arming commands
  wire arm      = cmd.valid && (cmd.code == `MMIT_MODE_ONE_SHOT ||
                                cmd.code == `MMIT_MODE_PERIODIC);
  wire bad_evt  = (cmd.event_code == 32'h0000_0000);
  wire bad_per  = (cmd.period < 32'(`MMIT_MIN_PERIOD)) ||
                  (cmd.period > max_period);
  wire arm_ok   = arm && !bad_evt && !bad_per;
  wire do_start = cmd.valid && cmd.code == `MMIT_MODE_FREE_RUN &&
                  (state == MMIT_ST_HALTED || state == MMIT_ST_IDLE);
  wire do_clear = cmd.valid && cmd.code == `MMIT_MODE_CLEARED;
  wire do_stop  = cmd.valid && cmd.code == `MMIT_MODE_HALTED;
  wire any_cmd  = arm_ok || do_start || do_clear || do_stop;
  wire counting = state == MMIT_ST_ONE_SHOT ||
                  state == MMIT_ST_PERIODIC || state == MMIT_ST_FREE_RUN;
  wire [31:0] next_count = 32'(count + 32'h0000_0001);
  wire hit      = tick && counting && (next_count >= period);
  // status words depend on mode
  wire armed    = state == MMIT_ST_ONE_SHOT || state == MMIT_ST_PERIODIC;
  assign status.value = (state == MMIT_ST_IDLE ||
                         state == MMIT_ST_CLEARED) ? 32'h0000_0000 : count;
  // mode word in its own variable, so every status field has one driver
  logic [31:0] mode_word;
  always_comb begin
    case (state)
      MMIT_ST_IDLE:     mode_word = 32'(`MMIT_MODE_IDLE);
      MMIT_ST_ONE_SHOT: mode_word = 32'(`MMIT_MODE_ONE_SHOT);
      MMIT_ST_PERIODIC: mode_word = 32'(`MMIT_MODE_PERIODIC);
      MMIT_ST_FREE_RUN: mode_word = 32'(`MMIT_MODE_FREE_RUN);
      MMIT_ST_HALTED:   mode_word = 32'(`MMIT_MODE_HALTED);
      MMIT_ST_CLEARED:  mode_word = 32'(`MMIT_MODE_CLEARED);
      default:          mode_word = 32'(`MMIT_MODE_IDLE);
    endcase
  end
  assign status.mode = mode_word;
  assign status.event_code = armed ? event_code : 32'h0000_0000;
  assign status.period = armed ? period :
                         (state == MMIT_ST_FREE_RUN) ? max_period :
                         32'h0000_0000;
  // mode machine; a command outranks a tick in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= MMIT_ST_IDLE;
      count      <= 32'h0000_0000;
      event_code <= 32'h0000_0000;
      period     <= 32'h0000_0000;
      fire       <= 1'b0;
      param_err  <= 1'b0;
    end else begin
      fire      <= hit && armed && !any_cmd;
      param_err <= arm && (bad_evt || bad_per);
      if (arm_ok) begin
        count      <= 32'h0000_0000;
        event_code <= cmd.event_code;
        period     <= cmd.period;
        state      <= (cmd.code == `MMIT_MODE_ONE_SHOT) ?
                      MMIT_ST_ONE_SHOT : MMIT_ST_PERIODIC;
      end else if (do_start) begin
        period     <= max_period;
        event_code <= 32'h0000_0000;
        state      <= MMIT_ST_FREE_RUN;
      end else if (do_clear) begin
        count      <= 32'h0000_0000;
        event_code <= 32'h0000_0000;
        state      <= MMIT_ST_CLEARED;
      end else if (do_stop) begin
        event_code <= 32'h0000_0000;
        state      <= MMIT_ST_HALTED;
      end else if (hit) begin
        // periodic and free run wrap to zero, so a free run started from a
        // count at the maximum can never climb past the channel's range
        count <= (state == MMIT_ST_ONE_SHOT) ? next_count :
                 32'h0000_0000;
        if (state == MMIT_ST_ONE_SHOT)
          state <= MMIT_ST_HALTED;
      end else if (tick && counting) begin
        count <= next_count;
      end
    end
  end
endmodule

// *** core/mmit_timer.sv ***
// interval timer block: APB slave, six channels, event output
// Function
// - one count equals 100 microseconds
// - zero event code rejected with error
// - channels start in idle mode 0x0000
// - six independent channels with own state
// - channels 4 and 5 are the two cascaded 32-bit timers
// - value read returns 32-bit present count
// - one-shot clears, fires once, then halts
// - periodic clears, fires every period
// - start from idle or halted free-runs at maximum period, no event
// - reset stops counting, zeroes count, cancels events
// - status returns count, mode, event, period
// - reported mode follows channel activity
// - event code reads zero unless armed
// - period reads programmed, maximum, or zero
// - idle reports zero count, period, event
// - halted holds count, period and event zero
// - cleared reports zero count, period, event
// - periods under 500 us rejected
// - periods above channel maximum rejected
`timescale 1ns/1ps
`include "mmit_regs.svh"
module mmit_timer (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output mmit_pkg::mmit_event_t evt
);
  import mmit_pkg::*;
  localparam int NCH = `MMIT_NUM_CH;
  // address split: channel index and word within channel
  wire [2:0] ch_sel   = paddr[7:`MMIT_CH_STRIDE_LOG2];
  wire [2:0] word_sel = paddr[4:2];
  wire       aligned  = paddr[1:0] == 2'b00;
  wire       mapped   = aligned && (ch_sel < 3'(NCH));
  wire       setup    = psel && !penable;
  wire       wr_take  = psel && penable && pready && pwrite && mapped;
  // staged arguments per channel, written before the command word
  logic [31:0] stage_evt [NCH];
  logic [31:0] stage_per [NCH];
  logic [NCH-1:0] err_flag;
  mmit_cmd_t    cmd   [NCH];
  mmit_status_t stat  [NCH];
  logic [NCH-1:0] fire;
  logic [NCH-1:0] perr;
  logic tick;
  mmit_prescaler u_pre (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick)
  );
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      wire is_cmd = wr_take && ch_sel == 3'(g) &&
                    word_sel == `MMIT_OFS_CMD;
      assign cmd[g].valid      = is_cmd;
      assign cmd[g].code       = pwdata[15:0];
      assign cmd[g].event_code = stage_evt[g];
      assign cmd[g].period     = stage_per[g];
      // channels 0..3 single 16-bit range, 4..5 cascaded 32-bit
      wire [31:0] ch_max = (g < `MMIT_NUM_SINGLE) ? `MMIT_MAX_SINGLE :
                           `MMIT_MAX_CASCADE;
      mmit_channel u_ch (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .tick       (tick),
        .max_period (ch_max),
        .cmd        (cmd[g]),
        .status     (stat[g]),
        .fire       (fire[g]),
        .param_err  (perr[g])
      );
    end
  endgenerate
  // read mux: four status words plus staged arguments and error flag
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (mapped) begin
      case (word_sel)
        `MMIT_OFS_EVENT:    rd_word = stage_evt[ch_sel];
        `MMIT_OFS_PERIOD:   rd_word = stage_per[ch_sel];
        `MMIT_OFS_VALUE:    rd_word = stat[ch_sel].value;
        `MMIT_OFS_MODE:     rd_word = stat[ch_sel].mode;
        `MMIT_OFS_PEND_EVT: rd_word = stat[ch_sel].event_code;
        `MMIT_OFS_PEND_PER: rd_word = stat[ch_sel].period;
        `MMIT_OFS_ERROR:    rd_word = {31'h0, err_flag[ch_sel]};
        default:            rd_word = 32'h0000_0000;
      endcase
    end
  end
  // event arbitration: lowest channel wins a same-cycle tie
  logic [2:0] fire_idx;
  always_comb begin
    fire_idx = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (fire[i]) fire_idx = 3'(i);
    end
  end
  // apb answer one cycle after setup; unmapped gives pslverr
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end
  // staged argument words and sticky error flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        stage_evt[i] <= 32'h0000_0000;
        stage_per[i] <= 32'h0000_0000;
      end
      err_flag <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_take && ch_sel == 3'(i)) begin
          if (word_sel == `MMIT_OFS_EVENT) stage_evt[i] <= pwdata;
          if (word_sel == `MMIT_OFS_PERIOD) stage_per[i] <= pwdata;
        end
        // a new error wins over a clear in the same cycle
        if (perr[i])
          err_flag[i] <= 1'b1;
        else if (wr_take && ch_sel == 3'(i) &&
                 word_sel == `MMIT_OFS_ERROR)
          err_flag[i] <= 1'b0;
      end
    end
  end
  // last nonzero pending code per channel; a one-shot already reads zero
  // in the cycle its fire strobe arrives here, so the code is kept aside
  logic [31:0] held_code [NCH];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) held_code[i] <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (stat[i].event_code != 32'h0000_0000)
          held_code[i] <= stat[i].event_code;
      end
    end
  end
  // event pulse register, one cycle per fire
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt <= '0;
    end else begin
      evt.fire       <= |fire;
      evt.channel    <= fire_idx;
      evt.event_code <= (|fire) ? held_code[fire_idx] : 32'h0000_0000;
    end
  end
endmodule

// *** testbench/mmit_monitor.sv ***
// concurrent checks on the interval timer ports
`timescale 1ns/1ps
module mmit_monitor (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire mmit_pkg::mmit_event_t evt
);
  import mmit_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // six windows of 0x20 bytes; anything above or unaligned is refused
  wire mapped = (paddr < 8'hC0) && (paddr[1:0] == 2'b00);
  wire setup  = psel && !penable;

  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no ready in the cycle after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_err_unmapped_addr: assert property (setup && !mapped |=> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped_addr: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 0)
    else $error("refused read returned data");
  // at most one event per tick, so a burst of fires means a stuck strobe
  a_fire_single_pulse: assert property (evt.fire |=> !evt.fire [*8])
    else $error("event strobe longer than one cycle");
  a_fire_code_nonzero: assert property (evt.fire |-> evt.event_code != 0)
    else $error("event raised with code zero");
  a_fire_channel_range: assert property (evt.fire |-> evt.channel < 3'h6)
    else $error("event names a missing channel");
  a_reset_quiet_start: assert property ($rose(rst_n) |->
    !pready && !evt.fire)
    else $error("outputs active right after reset");
endmodule
bind mmit_timer mmit_monitor mmit_monitor_i (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .evt(evt));

// *** testbench/mmit_timer_bench.sv ***
// self-checking bench for the interval timer over apb
`timescale 1ns/1ps
`include "mmit_regs.svh"
module mmit_timer_bench;
  import mmit_pkg::*;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  mmit_event_t evt;
  int          fail_count, samples_checked, n;

  mmit_timer mmit_timer_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt));

  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [7:0] ra(input int ch, input logic [2:0] ofs);
    ra = {ch[2:0], ofs, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // one apb transfer; an idle edge after it keeps psel from double writes
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // event and period are staged before the command word
  task automatic arm(input int ch, input logic [31:0] ev, input logic [31:0] per,
                     input logic [15:0] code);
    wr(ra(ch, `MMIT_OFS_EVENT), ev);
    wr(ra(ch, `MMIT_OFS_PERIOD), per);
    wr(ra(ch, `MMIT_OFS_CMD), {16'h0000, code});
  endtask

  task automatic status(input int ch, input logic [31:0] v, input logic [15:0] m,
                        input logic [31:0] ev, input logic [31:0] per);
    rdc(ra(ch, `MMIT_OFS_VALUE), v);
    rdc(ra(ch, `MMIT_OFS_MODE), {16'h0000, m});
    rdc(ra(ch, `MMIT_OFS_PEND_EVT), ev);
    rdc(ra(ch, `MMIT_OFS_PEND_PER), per);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // the one-shot needs five ticks of 25000 cycles, so allow a bit more
  initial begin
    repeat (140000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int c = 0; c < 6; c++) status(c, 0, `MMIT_MODE_IDLE, 0, 0);
    $display("test idle done");
    // arm early so the long wait overlaps the other tests
    arm(0, 32'h0000_0055, 32'h0000_0005, `MMIT_MODE_ONE_SHOT);
    rdc(ra(0, `MMIT_OFS_EVENT), 32'h0000_0055);
    status(0, 0, `MMIT_MODE_ONE_SHOT, 32'h0000_0055, 32'h0000_0005);
    xfer(1'b0, 8'hC0, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    xfer(1'b1, 8'h01, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    $display("test bus done");
    arm(2, 32'h0000_0000, 32'h0000_000A, `MMIT_MODE_ONE_SHOT);
    rdc(ra(2, `MMIT_OFS_ERROR), 32'h0000_0001);
    rdc(ra(2, `MMIT_OFS_MODE), 32'h0000_0000);
    wr(ra(2, `MMIT_OFS_ERROR), 32'h0000_0000);
    arm(2, 32'h0000_0007, 32'h0000_0004, `MMIT_MODE_PERIODIC);
    rdc(ra(2, `MMIT_OFS_ERROR), 32'h0000_0001);
    rdc(ra(2, `MMIT_OFS_MODE), 32'h0000_0000);
    wr(ra(2, `MMIT_OFS_ERROR), 32'h0000_0000);
    arm(2, 32'h0000_0007, 32'h0000_0005, `MMIT_MODE_PERIODIC);
    status(2, 0, `MMIT_MODE_PERIODIC, 32'h0000_0007, 32'h0000_0005);
    arm(3, 32'h0000_0007, 32'h0001_0000, `MMIT_MODE_ONE_SHOT);
    rdc(ra(3, `MMIT_OFS_ERROR), 32'h0000_0001);
    rdc(ra(3, `MMIT_OFS_MODE), 32'h0000_0000);
    arm(4, 32'h0000_0009, 32'h0001_0000, `MMIT_MODE_ONE_SHOT);
    status(4, 0, `MMIT_MODE_ONE_SHOT, 32'h0000_0009, 32'h0001_0000);
    $display("test refuse done");
    wr(ra(3, `MMIT_OFS_CMD), {16'h0000, `MMIT_MODE_FREE_RUN});
    rdc(ra(3, `MMIT_OFS_MODE), {16'h0000, `MMIT_MODE_FREE_RUN});
    rdc(ra(3, `MMIT_OFS_PEND_EVT), 32'h0000_0000);
    rdc(ra(3, `MMIT_OFS_PEND_PER), `MMIT_MAX_SINGLE);
    wr(ra(5, `MMIT_OFS_CMD), {16'h0000, `MMIT_MODE_FREE_RUN});
    rdc(ra(5, `MMIT_OFS_PEND_PER), `MMIT_MAX_CASCADE);
    wr(ra(3, `MMIT_OFS_CMD), {16'h0000, `MMIT_MODE_HALTED});
    rdc(ra(3, `MMIT_OFS_MODE), {16'h0000, `MMIT_MODE_HALTED});
    rdc(ra(3, `MMIT_OFS_PEND_PER), 32'h0000_0000);
    wr(ra(2, `MMIT_OFS_CMD), {16'h0000, `MMIT_MODE_CLEARED});
    status(2, 0, `MMIT_MODE_CLEARED, 0, 0);
    wr(ra(4, `MMIT_OFS_CMD), {16'h0000, `MMIT_MODE_CLEARED});
    rdc(ra(4, `MMIT_OFS_PEND_EVT), 32'h0000_0000);
    $display("test modes done");
    n = 0;
    while (evt.fire !== 1'b1 && n < 130000) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, evt.fire}, 32'h0000_0001);
    chk({29'h0, evt.channel}, 32'h0000_0000);
    chk(evt.event_code, 32'h0000_0055);
    @(posedge core_clk);
    status(0, 32'h0000_0005, `MMIT_MODE_HALTED, 0, 0);
    wr(ra(0, `MMIT_OFS_CMD), {16'h0000, `MMIT_MODE_FREE_RUN});
    rdc(ra(0, `MMIT_OFS_VALUE), 32'h0000_0005);
    $display("test fire done");
    stop_test();
  end
endmodule
